// ===== hdl/pin_sync.sv
// Purpose: two-stage synchroniser for a group of pin inputs
// Assumes: inputs are asynchronous to clk
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic [WIDTH-1:0]  async_in,
   input  wire logic [WIDTH-1:0]  reset_value,
   output logic      [WIDTH-1:0]  sync_out
);

   logic [WIDTH-1:0] meta_q;

   // two flops back to back, nothing taps the first
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         meta_q   <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

   // reset_value is not used; both stages always reset to zero
   logic unused_reset_value;
   assign unused_reset_value = ^reset_value;

endmodule : pin_sync
`default_nettype wire

// ===== hdl/static_bus_pkg.sv
// Purpose: shared types and constants for the external static bus port
// Assumes: one 10 MHz clock, synchronous active-low reset
// Notes:   request, answer and configuration travel as packed structs
package static_bus_pkg;

   localparam int ADDR_W        = 24;   // shared address bus width
   localparam int DATA_W        = 16;   // shared data bus width
   localparam int MEM_BANKS     = 2;    // rom/sram/nor banks
   localparam int IO_BANKS      = 3;    // memory-mapped i/o banks
   localparam int IO_WIN_BITS   = 14;   // 16 KB per i/o bank
   localparam int IO_BASE_W     = ADDR_W - IO_WIN_BITS;
   localparam int BOOT_WIN_BITS = 20;   // low window routed to bank 0 at boot
   localparam int WAIT_W        = 4;    // programmed strobe length width
   localparam int SYNC_STAGES   = 2;    // pin synchroniser depth
   localparam int SYNC_W        = DATA_W + 2;
   localparam int PIPE_W        = 2;

   // reset values and fixed lane fillers
   localparam logic [WAIT_W-1:0] WAIT_RESET  = 4'h0;
   localparam logic [PIPE_W-1:0] PIPE_RESET  = 2'h0;
   localparam logic [PIPE_W-1:0] PIPE_LOAD   = 2'h2;
   localparam logic [ADDR_W-1:0] ADDR_RESET  = 24'h000000;
   localparam logic [DATA_W-1:0] DATA_RESET  = 16'h0000;
   localparam logic [7:0]        BYTE_ZERO   = 8'h00;

   typedef enum logic [1:0] {
      KIND_MEM       = 2'h0,
      KIND_IO        = 2'h1,
      KIND_NAND_CMD  = 2'h2,
      KIND_NAND_ADDR = 2'h3
   } access_kind_type;

   typedef enum logic [3:0] {
      ST_IDLE   = 4'h1,
      ST_ACTIVE = 4'h2,
      ST_SAMPLE = 4'h4,
      ST_FINISH = 4'h8
   } bus_state_type;

   typedef struct packed {
      logic                valid;
      logic                write;
      access_kind_type     kind;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   wdata;
      logic [1:0]          byte_en;
   } access_req_type;

   typedef struct packed {
      logic                done;
      logic                error;
      logic [DATA_W-1:0]   rdata;
   } access_resp_type;

   typedef struct packed {
      logic [MEM_BANKS-1:0][ADDR_W-1:0]    mem_base;
      logic [MEM_BANKS-1:0][ADDR_W-1:0]    mem_mask;
      logic [IO_BANKS-1:0][IO_BASE_W-1:0]  io_base;
      logic [MEM_BANKS-1:0]                mem_wide;
      logic [IO_BANKS-1:0]                 io_wide;
      logic [MEM_BANKS-1:0][WAIT_W-1:0]    mem_wait;
      logic [IO_BANKS-1:0][WAIT_W-1:0]     io_wait;
      logic [WAIT_W-1:0]                   nand_wait;
      logic                                boot_map;
   } bus_cfg_type;

endpackage : static_bus_pkg

// ===== hdl/static_memory_io_bus_port.sv
// Purpose: pin-level port of the shared external static bus
// Assumes: requester holds req stable until resp.done pulses
// Notes:   every pin output is a flop; data bus is three signals
//
// Function
// R01 - one 16-bit two-way data bus, driven on writes, sampled on reads
// R02 - banks may be set to 8-bit width instead of 16-bit
// R03 - nand and static accesses share the data bus, one at a time
// R04 - three i/o banks, each with its own active-low select
// R05 - each i/o bank decodes a 16 KB window
// R06 - two rom/sram/nor banks, each with its own active-low select
// R07 - programmable decode maps addresses onto the selected bank
// R08 - bank 0 may serve as boot bank through a low address window
// R09 - low wait input stretches the access while it stays low
// R10 - shared active-low read enable asserted during reads
// R11 - upper write enable asserted when writing bits 15 to 8
// R12 - lower write enable for bits 7 to 0, or whole 8-bit bus
// R13 - nand command latch high while a command byte is on the bus
// R14 - nand address latch high while an address byte is on the bus
// R15 - active-low enable selects nand bank 1 during its accesses
// R16 - 24-bit address bus shared by all static and i/o banks
// R17 - nand ready/busy low means busy, high means ready
// R18 - at most one bank select at a time, data bus released otherwise
// R19 - read and write enables stay high while the bus is idle
`timescale 1ns/1ns
`default_nettype none
module static_memory_io_bus_port (
   input  wire logic                                   ref_clk,
   input  wire logic                                   rst_n,
   input  wire static_bus_pkg::access_req_type         req,
   output var  static_bus_pkg::access_resp_type        resp,
   input  wire static_bus_pkg::bus_cfg_type            cfg,
   output logic                                        flash_ready,
   output logic [static_bus_pkg::ADDR_W-1:0]           shared_address_bus,
   input  wire logic [static_bus_pkg::DATA_W-1:0]      shared_data_bus_in,
   output logic [static_bus_pkg::DATA_W-1:0]           shared_data_bus_out,
   output logic                                        shared_data_bus_oe_n,
   output logic [static_bus_pkg::IO_BANKS-1:0]         io_bank_selects_n,
   output logic [static_bus_pkg::MEM_BANKS-1:0]        mem_bank_selects_n,
   input  wire logic                                   ext_wait_n,
   output logic                                        bus_read_enable_n,
   output logic                                        upper_byte_write_n,
   output logic                                        lower_byte_write_n,
   output logic                                        flash_cmd_latch,
   output logic                                        flash_addr_latch,
   output logic                                        flash_bank1_enable_n,
   input  wire logic                                   flash_ready_busy_n
);
   import static_bus_pkg::*;

   // synchronised pins
   logic [SYNC_W-1:0]      sync_raw;
   logic                   wait_s;
   logic                   ready_s;
   logic [DATA_W-1:0]      data_s;

   // decode wires
   logic [MEM_BANKS-1:0]   mem_hit;
   logic [IO_BANKS-1:0]    io_hit;
   logic [MEM_BANKS-1:0]   mem_sel;
   logic [IO_BANKS-1:0]    io_sel;
   logic                   boot_hit;
   logic                   is_nand;
   logic                   is_mem;
   logic                   is_io;
   logic                   any_hit;
   logic                   wide;
   logic [WAIT_W-1:0]      wait_len;
   logic                   accept;
   logic [7:0]             narrow_byte;
   logic [DATA_W-1:0]      wdata_lane;
   logic [DATA_W-1:0]      rdata_lane;

   // state
   bus_state_type          state_q;
   bus_state_type          state_d;
   logic [WAIT_W-1:0]      cnt_q;
   logic [PIPE_W-1:0]      pipe_q;
   logic                   wide_q;
   logic                   cnt_zero;
   logic                   pipe_zero;

   // pins passed through two flops before use
   pin_sync #(
      .WIDTH       (SYNC_W)
   ) u_pin_sync (
      .ref_clk     (ref_clk),
      .rst_n       (rst_n),
      .async_in    ({~ext_wait_n, ~flash_ready_busy_n, shared_data_bus_in}),
      .reset_value ({SYNC_W{1'b0}}),
      .sync_out    (sync_raw)
   );

   // inverted carriage so reset reads as not waiting and ready
   assign wait_s  = sync_raw[SYNC_W-1];                   // R09
   assign ready_s = ~sync_raw[SYNC_W-2];                  // R17
   assign data_s  = sync_raw[DATA_W-1:0];

   // access kind
   assign is_mem  = (req.kind == KIND_MEM);
   assign is_io   = (req.kind == KIND_IO);
   assign is_nand = (req.kind == KIND_NAND_CMD) || (req.kind == KIND_NAND_ADDR);

   // per-bank address compare
   genvar gi;
   generate
      for (gi = 0; gi < MEM_BANKS; gi++)
      begin : g_mem_hit
         assign mem_hit[gi] = is_mem &&
            ((req.addr & cfg.mem_mask[gi]) == cfg.mem_base[gi]);   // R07
      end
      for (gi = 0; gi < IO_BANKS; gi++)
      begin : g_io_hit
         assign io_hit[gi] = is_io &&
            (req.addr[ADDR_W-1:IO_WIN_BITS] == cfg.io_base[gi]);   // R05
      end
   endgenerate

   // boot window forces bank 0
   assign boot_hit = is_mem && cfg.boot_map &&
                     (req.addr[ADDR_W-1:BOOT_WIN_BITS] == '0);     // R08

   // priority to one-hot, lowest bank wins
   assign mem_sel[0] = boot_hit | mem_hit[0];                      // R18
   assign mem_sel[1] = ~mem_sel[0] & mem_hit[1];                   // R06
   assign io_sel[0]  = io_hit[0];                                  // R04
   assign io_sel[1]  = io_hit[1] & ~io_hit[0];
   assign io_sel[2]  = io_hit[2] & ~io_hit[1] & ~io_hit[0];

   assign any_hit = (|mem_sel) | (|io_sel) | is_nand;

   // nand cycles always use the low byte
   assign wide = (|(mem_sel & cfg.mem_wide)) | (|(io_sel & cfg.io_wide));  // R02

   // programmed strobe length of the selected bank
   assign wait_len = is_nand    ? cfg.nand_wait   :
                     mem_sel[0] ? cfg.mem_wait[0] :
                     mem_sel[1] ? cfg.mem_wait[1] :
                     io_sel[0]  ? cfg.io_wait[0]  :
                     io_sel[1]  ? cfg.io_wait[1]  :
                     cfg.io_wait[2];

   // nand waits for ready; done pulse blocks a stale re-accept
   assign accept = (state_q == ST_IDLE) && req.valid && !resp.done &&
                   (!is_nand || ready_s);                          // R17

   // write lane: narrow banks take the enabled byte on bits 7..0
   assign narrow_byte = req.byte_en[0] ? req.wdata[7:0] : req.wdata[15:8];
   assign wdata_lane  = (wide && !is_nand) ? req.wdata
                                           : {BYTE_ZERO, narrow_byte};
   assign rdata_lane  = wide_q ? data_s : {BYTE_ZERO, data_s[7:0]};  // R02

   assign cnt_zero  = (cnt_q == WAIT_RESET);
   assign pipe_zero = (pipe_q == PIPE_RESET);

   // next state
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE:
         begin
            if (accept && any_hit)
               state_d = ST_ACTIVE;
         end
         ST_ACTIVE:
         begin
            if (cnt_zero)
               state_d = ST_SAMPLE;
         end
         ST_SAMPLE:
         begin
            if (pipe_zero && !wait_s)                      // R09
               state_d = ST_FINISH;
         end
         ST_FINISH:
         begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // state and counters
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         state_q <= ST_IDLE;
         cnt_q   <= WAIT_RESET;
         pipe_q  <= PIPE_RESET;
         wide_q  <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         if (state_q == ST_IDLE)
         begin
            cnt_q  <= wait_len;
            pipe_q <= PIPE_LOAD;                            // covers sync lag
            wide_q <= wide && !is_nand;
         end
         else
         begin
            if (!cnt_zero)
               cnt_q <= cnt_q - 1'b1;
            if (state_q == ST_SAMPLE && !pipe_zero)
               pipe_q <= pipe_q - 1'b1;
         end
      end
   end

   // address, selects and nand latches held for the whole access
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         shared_address_bus   <= ADDR_RESET;
         mem_bank_selects_n   <= '1;
         io_bank_selects_n    <= '1;
         flash_bank1_enable_n <= 1'b1;
         flash_cmd_latch      <= 1'b0;
         flash_addr_latch     <= 1'b0;
      end
      else if (state_q == ST_IDLE && state_d == ST_ACTIVE)
      begin
         shared_address_bus   <= req.addr;                         // R16
         mem_bank_selects_n   <= ~mem_sel;                         // R06
         io_bank_selects_n    <= ~io_sel;                          // R04
         flash_bank1_enable_n <= ~is_nand;                         // R15
         flash_cmd_latch      <= (req.kind == KIND_NAND_CMD);      // R13
         flash_addr_latch     <= (req.kind == KIND_NAND_ADDR);     // R14
      end
      else if (state_q == ST_FINISH)
      begin
         mem_bank_selects_n   <= '1;                               // R18
         io_bank_selects_n    <= '1;
         flash_bank1_enable_n <= 1'b1;
         flash_cmd_latch      <= 1'b0;
         flash_addr_latch     <= 1'b0;
      end
   end

   // strobes: asserted on entry, dropped when the stretch ends
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         bus_read_enable_n  <= 1'b1;
         upper_byte_write_n <= 1'b1;
         lower_byte_write_n <= 1'b1;
      end
      else if (state_q == ST_IDLE && state_d == ST_ACTIVE && !is_nand)
      begin
         bus_read_enable_n  <= req.write;                          // R10
         upper_byte_write_n <= ~(req.write && wide && req.byte_en[1]);  // R11
         lower_byte_write_n <= ~(req.write &&
                                 (wide ? req.byte_en[0] : 1'b1));  // R12
      end
      else if (state_d == ST_FINISH || state_q == ST_FINISH)
      begin
         bus_read_enable_n  <= 1'b1;                               // R19
         upper_byte_write_n <= 1'b1;
         lower_byte_write_n <= 1'b1;
      end
   end

   // data bus: driven for writes and nand bytes, released otherwise
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         shared_data_bus_out  <= DATA_RESET;
         shared_data_bus_oe_n <= 1'b1;
      end
      else if (state_q == ST_IDLE && state_d == ST_ACTIVE)
      begin
         shared_data_bus_out  <= wdata_lane;                       // R01
         shared_data_bus_oe_n <= ~(req.write || is_nand);          // R03
      end
      else if (state_q == ST_FINISH)
      begin
         shared_data_bus_oe_n <= 1'b1;                             // R18
      end
   end

   // answer: read data captured at the end of the stretch
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         resp <= '0;
      end
      else
      begin
         resp.done  <= (state_q == ST_FINISH) || (accept && !any_hit);
         resp.error <= accept && !any_hit;                 // unmapped address
         if (state_q == ST_SAMPLE && state_d == ST_FINISH)
            resp.rdata <= rdata_lane;                      // R01
      end
   end

   // ready/busy level seen by the requester
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         flash_ready <= 1'b1;
      else
         flash_ready <= ready_s;                           // R17
   end

endmodule : static_memory_io_bus_port
`default_nettype wire

// ===== verif/static_bus_far_model.sv
// Purpose: far-side memory, i/o and nand status model
// Assumes: design strobes change on the rising edge
// Notes:   released data bus floats up to all ones
`timescale 1ns/1ns
`default_nettype none
module static_bus_far_model (
   input  wire logic        ref_clk,
   input  wire logic [4:0]  sel_n,
   input  wire logic        rd_n,
   input  wire logic        up_n,
   input  wire logic        lo_n,
   input  wire logic        oe_n,
   input  wire logic [15:0] dout,
   input  wire logic [23:0] addr,
   input  wire logic [3:0]  stretch,
   input  wire logic        busy,
   output logic      [15:0] din,
   output logic             wait_n,
   output logic             rb_n
);
   logic [15:0] mem [16];
   logic [3:0]  cnt_q;
   wire         hit = (&sel_n) === 1'b0;
   // cleared store so reads never float
   initial
   begin
      foreach (mem[i]) mem[i] = 16'h0000;
      cnt_q = 4'h0;
   end
   // byte lane writes and wait stretch count
   always @(posedge ref_clk)
   begin
      if (hit && !lo_n) mem[addr[3:0]][7:0] <= din[7:0];
      if (hit && !up_n) mem[addr[3:0]][15:8] <= din[15:8];
      cnt_q <= hit ? cnt_q + 4'((cnt_q < stretch)) : 4'h0;
   end
   // wire level: device, model on read, else pull-up
   assign din = (oe_n === 1'b0) ? dout : (hit && rd_n === 1'b0) ? mem[addr[3:0]] : 16'hFFFF;
   assign wait_n = !(hit && cnt_q < stretch);
   assign rb_n = !busy;
endmodule : static_bus_far_model
`default_nettype wire

// ===== verif/static_bus_props.sv
// Purpose: concurrent checks on the static bus port pins
// Assumes: one clock, synchronous active-low reset
// Notes:   bound onto every instance of the port
`timescale 1ns/1ns
`default_nettype none
module static_bus_props (
   input  wire logic                                ref_clk,
   input  wire logic                                rst_n,
   input  wire static_bus_pkg::access_resp_type     resp,
   input  wire static_bus_pkg::bus_cfg_type         cfg,
   input  wire logic [static_bus_pkg::ADDR_W-1:0]   shared_address_bus,
   input  wire logic                                shared_data_bus_oe_n,
   input  wire logic [static_bus_pkg::IO_BANKS-1:0] io_bank_selects_n,
   input  wire logic [static_bus_pkg::MEM_BANKS-1:0] mem_bank_selects_n,
   input  wire logic                                ext_wait_n,
   input  wire logic                                bus_read_enable_n,
   input  wire logic                                upper_byte_write_n,
   input  wire logic                                lower_byte_write_n,
   input  wire logic                                flash_cmd_latch,
   input  wire logic                                flash_addr_latch,
   input  wire logic                                flash_bank1_enable_n
);
   import static_bus_pkg::*;
   // no static bank selected, and no bank at all
   wire st_idle  = &{io_bank_selects_n, mem_bank_selects_n};
   wire all_idle = st_idle && flash_bank1_enable_n;
   wire [9:0] top = shared_address_bus[23:14];

   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   a_one_select:
   assert property ($countones(~{io_bank_selects_n, mem_bank_selects_n,
                                 flash_bank1_enable_n}) <= 1)
      else $error("more than one bank select low");
   a_bus_release:
   assert property (!shared_data_bus_oe_n |-> !all_idle)
      else $error("data bus driven with no bank selected");
   a_idle_quiet:
   assert property (all_idle |-> bus_read_enable_n && upper_byte_write_n && lower_byte_write_n)
      else $error("strobe low while bus idle");
   a_read_no_drive:
   assert property (!bus_read_enable_n |-> shared_data_bus_oe_n && !st_idle)
      else $error("read enable without static select or with bus driven");
   a_write_drive:
   assert property (!(upper_byte_write_n && lower_byte_write_n)
                    |-> !shared_data_bus_oe_n && bus_read_enable_n)
      else $error("write strobe without data driven");
   a_wait_holds:
   assert property ((!ext_wait_n && !st_idle) [*4] |=> !resp.done)
      else $error("access ended while wait held low");
   a_miss_quiet:
   assert property (resp.error |-> resp.done && all_idle && $past(all_idle))
      else $error("unmapped access moved a select");
   a_flash_latch:
   assert property ((flash_cmd_latch || flash_addr_latch)
                    |-> !(flash_cmd_latch && flash_addr_latch)
                    && !flash_bank1_enable_n && st_idle && !shared_data_bus_oe_n)
      else $error("nand latch without nand select and data");
   a_io_window:
   assert property ((io_bank_selects_n[0] || top == cfg.io_base[0]) && (io_bank_selects_n[1]
                    || top == cfg.io_base[1]) && (io_bank_selects_n[2] || top == cfg.io_base[2]))
      else $error("i/o select outside its window");
endmodule : static_bus_props

bind static_memory_io_bus_port static_bus_props chk_u (
   .ref_clk, .rst_n, .resp, .cfg, .shared_address_bus, .shared_data_bus_oe_n,
   .io_bank_selects_n, .mem_bank_selects_n, .ext_wait_n, .bus_read_enable_n,
   .upper_byte_write_n, .lower_byte_write_n, .flash_cmd_latch, .flash_addr_latch,
   .flash_bank1_enable_n);
`default_nettype wire

// ===== verif/test_static_memory_io_bus_port.sv
// Purpose: self-checking bench for the external static bus port
// Assumes: inputs change on the falling edge of ref_clk
// Notes:   far-side model answers reads and stretches on request
`timescale 1ns/1ns
`default_nettype none
module test_static_memory_io_bus_port;
   import static_bus_pkg::*;
   logic            ref_clk = 1'b0;
   logic            rst_n = 1'b0;
   access_req_type  req = '0;
   access_resp_type resp;
   bus_cfg_type     cfg = '0;
   logic [23:0]     sab;
   logic [15:0]     din, dout;
   logic [2:0]      io_n;
   logic [1:0]      mem_n;
   logic            oe_n, rd_n, up_n, lo_n, cle, ale, nce, wait_n, rb_n, rdy, err_got;
   logic [3:0]      stretch = 4'h0;
   logic            busy = 1'b0;
   logic [4:0]      sel_seen;
   logic [5:0]      seen;
   int              err_total = 0;
   int              samples_checked = 0;
   int              n_cyc;

   static_memory_io_bus_port dut_u (
      .ref_clk, .rst_n, .req, .resp, .cfg, .flash_ready(rdy), .shared_address_bus(sab),
      .shared_data_bus_in(din), .shared_data_bus_out(dout), .shared_data_bus_oe_n(oe_n),
      .io_bank_selects_n(io_n), .mem_bank_selects_n(mem_n), .ext_wait_n(wait_n),
      .bus_read_enable_n(rd_n), .upper_byte_write_n(up_n), .lower_byte_write_n(lo_n),
      .flash_cmd_latch(cle), .flash_addr_latch(ale), .flash_bank1_enable_n(nce),
      .flash_ready_busy_n(rb_n));
   static_bus_far_model far_u (
      .ref_clk, .sel_n({io_n, mem_n}), .rd_n, .up_n, .lo_n, .oe_n, .dout, .addr(sab),
      .stretch, .busy, .din, .wait_n, .rb_n);

   always #50 ref_clk = ~ref_clk;

   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // one request held until done, pins watched each cycle
   task automatic access(input access_kind_type k, input logic w, input logic [23:0] a,
                         input logic [15:0] d, input logic [1:0] be);
      @(negedge ref_clk);
      req <= '{1'b1, w, k, a, d, be};
      sel_seen = 5'h1F;
      seen = 6'h00;
      n_cyc = 0;
      do
      begin
         @(posedge ref_clk);
         #1;
         n_cyc++;
         sel_seen &= {io_n, mem_n};
         seen |= {~rd_n, ~up_n, ~lo_n, cle, ale, ~nce};
      end while (resp.done !== 1'b1 && n_cyc < 300);
      err_got = resp.error;
      check(resp.done, 1'b1);
      @(negedge ref_clk);
      req.valid <= 1'b0;
   endtask : access

   task automatic t_mem16();
      access(KIND_MEM, 1'b1, 24'h100003, 16'hA55A, 2'h3);
      check(sel_seen, 5'h1E);
      check(seen, 6'h18);
      check(n_cyc, 24'h7);
      access(KIND_MEM, 1'b1, 24'h100003, 16'h1234, 2'h2);
      check(seen, 6'h10);
      access(KIND_MEM, 1'b0, 24'h100003, 16'h0000, 2'h3);
      check(seen, 6'h20);
      check(resp.rdata, 16'h125A);
      check(sab, 24'h100003);
   endtask : t_mem16

   task automatic t_mem8();
      access(KIND_MEM, 1'b1, 24'h200005, 16'hC396, 2'h2);
      check({sel_seen, seen}, {5'h1D, 6'h08});
      access(KIND_MEM, 1'b0, 24'h200005, 16'h0000, 2'h3);
      check(resp.rdata, 16'h00C3);
   endtask : t_mem8

   task automatic t_io();
      for (int i = 0; i < 3; i++)
      begin
         access(KIND_IO, 1'b1, {10'h300 + 10'(i), 14'h3FFF}, 16'h0F00 + 16'(i), 2'h3);
         check(sel_seen, 5'h1F & ~(5'h04 << i));
         access(KIND_IO, 1'b0, {10'h300 + 10'(i), 14'h3FFF}, 16'h0000, 2'h3);
         check(resp.rdata, 16'h0F00 + 16'(i));
      end
      access(KIND_IO, 1'b0, 24'hC0C000, 16'h0000, 2'h3);
      check({err_got, sel_seen}, 6'h3F);
      check(n_cyc, 24'h1);
      access(KIND_MEM, 1'b1, 24'h500000, 16'hFFFF, 2'h3);
      check({err_got, sel_seen, seen}, 12'hFC0);
   endtask : t_io

   task automatic t_boot();
      cfg.boot_map = 1'b1;
      access(KIND_MEM, 1'b0, 24'h000004, 16'h0000, 2'h3);
      check({err_got, sel_seen}, 6'h1E);
      cfg.boot_map = 1'b0;
      access(KIND_MEM, 1'b0, 24'h000004, 16'h0000, 2'h3);
      check(err_got, 1'b1);
   endtask : t_boot

   task automatic t_wait();
      stretch = 4'h8;
      access(KIND_MEM, 1'b0, 24'h200005, 16'h0000, 2'h3);
      check(n_cyc >= 12 && n_cyc <= 16, 1'b1);
      stretch = 4'h0;
   endtask : t_wait

   task automatic t_nand();
      busy = 1'b1;
      repeat (4) @(negedge ref_clk);
      check(rdy, 1'b0);
      fork
         access(KIND_NAND_CMD, 1'b1, 24'h000000, 16'h0070, 2'h1);
         begin
            repeat (6) @(negedge ref_clk);
            check({cle, nce}, 2'h1);
            busy = 1'b0;
         end
      join
      check({sel_seen, seen}, {5'h1F, 6'h05});
      check(dout, 16'h0070);
      check(n_cyc > 8, 1'b1);
      access(KIND_NAND_ADDR, 1'b1, 24'h000000, 16'h0012, 2'h1);
      check({sel_seen, seen}, {5'h1F, 6'h03});
      check(rdy, 1'b1);
   endtask : t_nand

   task automatic tally_and_finish();
      if (err_total == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish

   // bank map, reset check, then every scenario
   initial
   begin
      cfg.mem_base[0] = 24'h100000;
      cfg.mem_base[1] = 24'h200000;
      cfg.mem_mask = {2{24'hF00000}};
      cfg.io_base[0] = 10'h300;
      cfg.io_base[1] = 10'h301;
      cfg.io_base[2] = 10'h302;
      cfg.mem_wide = 2'h1;
      cfg.io_wide = 3'h7;
      cfg.mem_wait[0] = 4'h1;
      repeat (8) @(negedge ref_clk);
      check({io_n, mem_n, nce, rd_n, up_n, lo_n}, 9'h1FF);
      check({oe_n, cle, ale}, 3'h4);
      rst_n = 1'b1;
      t_mem16();
      t_mem8();
      t_io();
      t_boot();
      t_wait();
      t_nand();
      tally_and_finish();
   end

   // hang guard, far beyond the roughly 140 cycles needed
   initial
   begin
      repeat (3000) @(posedge ref_clk);
      err_total++;
      tally_and_finish();
   end
endmodule : test_static_memory_io_bus_port
`default_nettype wire
